//--- acp_regs.vh
`ifndef ACP_REGS_VH
`define ACP_REGS_VH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ACP_AW             12
`define ACP_OFF_CTRL       12'h000
`define ACP_OFF_STAT       12'h004
`define ACP_OFF_DATA       12'h008

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define ACP_CTRL_RST       32'h07d0_0001
`define ACP_CTRL_CONV      0
`define ACP_CTRL_CAL       1
`define ACP_CTRL_DEC_LO    16
`define ACP_CTRL_DEC_HI    27

// ----------------------------------------------------------------
// status fields
// ----------------------------------------------------------------
`define ACP_STAT_LVL_LO    0
`define ACP_STAT_LVL_HI    4
`define ACP_STAT_AVAIL     8
`define ACP_STAT_CAL       9
`define ACP_STAT_POLERR    10
`define ACP_STAT_STBY      11
`define ACP_STAT_SYNC      12
`define ACP_STAT_POL       13

// ----------------------------------------------------------------
// synchroniser lanes
// ----------------------------------------------------------------
`define ACP_NSYNC          8
`define ACP_SI_SCLK        0
`define ACP_SI_CS          1
`define ACP_SI_MOD         2
`define ACP_SI_MCLK        3
`define ACP_SI_POL         4
`define ACP_SI_SYNC        5
`define ACP_SI_RST         6
`define ACP_SI_STBY        7

// ----------------------------------------------------------------
// counts
// ----------------------------------------------------------------
`define ACP_WORD_BITS      24
`define ACP_BLANK_MCLK     12'd500
`define ACP_CAL_MCLK       16'd1000

`endif

//--- acp_fifo.v
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------------------------------
// result word fifo
// ----------------------------------------------------------------
module acp_fifo #(
  parameter WIDTH = 24,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and clear
  input  wire             clock,
  input  wire             clr,
  // fill side
  input  wire             in_valid,
  input  wire [WIDTH-1:0] in_data,
  output wire             in_ready,
  // drain side
  output wire             out_valid,
  output wire [WIDTH-1:0] out_data,
  input  wire             out_ready,
  // fill level
  output wire [AW:0]      level
);

  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wp_q;
  reg [AW-1:0]    rp_q;
  reg [AW:0]      cnt_q;
  wire            push;
  wire            pop;

  localparam [AW:0] FULL = DEPTH;

  assign in_ready  = (cnt_q != FULL);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data  = mem[rp_q];
  assign level     = cnt_q;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always @(posedge clock) begin
    if (push) begin
      mem[wp_q] <= in_data;
    end
  end

  always @(posedge clock) begin
    if (clr) begin
      wp_q  <= {AW{1'b0}};
      rp_q  <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_q <= wp_q + 1'b1;
      end
      if (pop) begin
        rp_q <= rp_q + 1'b1;
      end
      if (push & ~pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop & ~push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end

endmodule

`default_nettype wire

//--- acp_ctrl.v
`timescale 1ns/10ps
`default_nettype none
`include "acp_regs.vh"

// Behaviour
// (RULE1) serial clock may run continuously or in bursts; results are identical.
// (RULE2) polarity select low: first transfer edge rises, clock idles low.
// (RULE3) polarity select high: first transfer edge falls, clock idles high.
// (RULE4) sync low holds filter, filter control, calibration and modulator in reset.
// (RULE5) sync leaves serial interface and a low word ready untouched.
// (RULE6) reset pin low returns control, interface, filter, modulator to power-on.
// (RULE7) standby low shuts down analog and digital circuitry.
// (RULE8) with external master clock, master clock output is its inverse.
// (RULE9) active serial edge is falling when polarity select is 1, else rising.
// (RULE10) word ready low on new word, high after read or 500 periods before update.
// (RULE11) reset, sync and standby inputs are synchronised before use.
module acp_ctrl #(
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW    = 4
) (
  // system
  input  wire        clock,
  input  wire        nrst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata_q,
  output reg         pready_q,
  output reg         pslverr_q,
  // serial link pins
  input  wire        sclk,
  input  wire        cs_n,
  input  wire        edge_polarity_sel,
  output reg         dout_q,
  output reg         dout_oe_q,
  output reg         word_ready_n_q,
  // control pins
  input  wire        sync_n,
  input  wire        reset_n,
  input  wire        standby_n,
  // master clock and analog side
  input  wire        mclk_in,
  output reg         mclk_out_q,
  input  wire        mod_bit,
  output reg         mod_reset_q,
  output reg         analog_pd_q
);

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  function [2:0] acp_dec;
    input [11:0] a;
    begin
      case (a)
        `ACP_OFF_CTRL: acp_dec = 3'h1;
        `ACP_OFF_STAT: acp_dec = 3'h2;
        `ACP_OFF_DATA: acp_dec = 3'h4;
        default:       acp_dec = 3'h0;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------------
  wire [`ACP_NSYNC-1:0] pins_raw;
  reg  [`ACP_NSYNC-1:0] s1_q;
  reg  [`ACP_NSYNC-1:0] s2_q;
  reg                   sclk_prev_q;
  reg                   mclk_prev_q;
  reg                   cs_prev_q;

  assign pins_raw = {standby_n, reset_n, sync_n, edge_polarity_sel,
                     mclk_in, mod_bit, cs_n, sclk};

  genvar gi;
  generate
    for (gi = 0; gi < `ACP_NSYNC; gi = gi + 1) begin : g_sync
      // the first stage feeds only the second one
      always @(posedge clock) begin
        if (!nrst) begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
        end else begin
          s1_q[gi] <= pins_raw[gi];
          s2_q[gi] <= s1_q[gi];
        end
      end
    end
  endgenerate

  wire sclk_s  = s2_q[`ACP_SI_SCLK];
  wire cs_n_s  = s2_q[`ACP_SI_CS];
  wire mod_s   = s2_q[`ACP_SI_MOD];
  wire mclk_s  = s2_q[`ACP_SI_MCLK];
  wire pol_s   = s2_q[`ACP_SI_POL];
  wire sync_s  = s2_q[`ACP_SI_SYNC];   // see (RULE11)
  wire rstp_s  = s2_q[`ACP_SI_RST];    // see (RULE11)
  wire stby_s  = s2_q[`ACP_SI_STBY];   // see (RULE11)

  // pin reset clears what a power-on would, except the bus handshake, input synchronisers and edge detectors
  wire rst_all = ~nrst | ~rstp_s;      // see (RULE6)
  wire sync_hold = ~sync_s;
  wire run = stby_s;                   // see (RULE7)

  always @(posedge clock) begin
    if (!nrst) begin
      sclk_prev_q <= 1'b0;
      mclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else begin
      sclk_prev_q <= sclk_s;
      mclk_prev_q <= mclk_s;
      cs_prev_q   <= cs_n_s;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_prev_q;
  wire sclk_fall = ~sclk_s & sclk_prev_q;
  wire act_edge  = pol_s ? sclk_fall : sclk_rise;   // see (RULE9)
  wire idle_edge = pol_s ? sclk_rise : sclk_fall;
  wire mclk_tick = mclk_s & ~mclk_prev_q;

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg                        conv_en_q;
  reg  [11:0]                decim_q;
  reg  [15:0]                cal_cnt_q;
  reg                        pol_err_q;
  reg  [`ACP_WORD_BITS-1:0]  result_q;
  reg  [`ACP_WORD_BITS-1:0]  acc_q;
  reg  [11:0]                dcnt_q;
  reg                        pend_q;
  reg  [`ACP_WORD_BITS-1:0]  sr_q;
  reg  [4:0]                 bitcnt_q;
  reg                        pop_q;
  wire                       f_in_ready;
  wire                       f_out_valid;
  wire [`ACP_WORD_BITS-1:0]  f_out_data;
  wire [FIFO_AW:0]           f_level;
  wire                       word_done;

  wire       acc_ph   = psel & penable & pready_q;
  wire [2:0] hit      = acp_dec(paddr);
  wire       wr_ctrl  = acc_ph & pwrite & hit[0];
  wire       wr_stat  = acc_ph & pwrite & hit[1];
  wire       cal_busy = (cal_cnt_q != 16'h0000);
  // reset image of the control word, sliced per field below
  wire [31:0] ctrl_rst = `ACP_CTRL_RST;

  wire [31:0] stat_word = {18'h00000, pol_s, sync_hold, ~stby_s, pol_err_q, cal_busy,
                           ~word_ready_n_q, 3'h0, f_level};
  wire [31:0] ctrl_word = {4'h0, decim_q, 14'h0000, cal_busy, conv_en_q};

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  // one wait state: pready rises in the second access cycle
  always @(posedge clock) begin
    if (!nrst) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
    end else begin
      pready_q  <= psel & penable & ~pready_q;
      pslverr_q <= psel & penable & ~pready_q & (hit == 3'h0);
      if (psel & penable & ~pready_q & ~pwrite) begin
        case (hit)
          3'h1:    prdata_q <= ctrl_word;
          3'h2:    prdata_q <= stat_word;
          3'h4:    prdata_q <= {8'h00, result_q};
          default: prdata_q <= 32'h0000_0000;
        endcase
      end
    end
  end

  always @(posedge clock) begin
    if (rst_all) begin
      conv_en_q <= ctrl_rst[`ACP_CTRL_CONV];
      decim_q   <= ctrl_rst[`ACP_CTRL_DEC_HI:`ACP_CTRL_DEC_LO];
    end else if (wr_ctrl) begin
      conv_en_q <= pwdata[`ACP_CTRL_CONV];
      decim_q   <= pwdata[`ACP_CTRL_DEC_HI:`ACP_CTRL_DEC_LO];
    end
  end

  // ----------------------------------------------------------------
  // calibration sequencer
  // ----------------------------------------------------------------
  always @(posedge clock) begin
    if (rst_all | sync_hold) begin     // see (RULE4)
      cal_cnt_q <= 16'h0000;
    end else if (wr_ctrl & pwdata[`ACP_CTRL_CAL] & ~cal_busy) begin
      cal_cnt_q <= `ACP_CAL_MCLK;
    end else if (cal_busy & mclk_tick & run) begin
      cal_cnt_q <= cal_cnt_q - 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // decimating filter
  // ----------------------------------------------------------------
  // a full fifo stalls the filter rather than dropping a word
  // at-or-above, so a smaller decimation written mid-word ends the word at once
  wire dec_last = (dcnt_q >= decim_q - 12'h001);

  always @(posedge clock) begin
    if (rst_all | sync_hold) begin     // see (RULE4)
      acc_q  <= {`ACP_WORD_BITS{1'b0}};
      dcnt_q <= 12'h000;
    end else if (mclk_tick & run & conv_en_q & ~cal_busy & ~pend_q) begin
      if (dec_last) begin
        acc_q  <= {`ACP_WORD_BITS{1'b0}};
        dcnt_q <= 12'h000;
      end else begin
        acc_q  <= acc_q + {{(`ACP_WORD_BITS-1){1'b0}}, mod_s};
        dcnt_q <= dcnt_q + 12'h001;
      end
    end
  end

  wire word_end = mclk_tick & run & conv_en_q & ~cal_busy & ~pend_q & dec_last;

  always @(posedge clock) begin
    if (rst_all) begin
      pend_q   <= 1'b0;
      result_q <= {`ACP_WORD_BITS{1'b0}};
    end else if (word_end & ~sync_hold) begin
      pend_q   <= 1'b1;
      result_q <= acc_q + {{(`ACP_WORD_BITS-1){1'b0}}, mod_s};
    end else if (f_in_ready) begin
      pend_q   <= 1'b0;
    end
  end

  acp_fifo #(
    .WIDTH (`ACP_WORD_BITS),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clock     (clock),
    .clr       (rst_all),
    .in_valid  (pend_q),
    .in_data   (result_q),
    .in_ready  (f_in_ready),
    .out_valid (f_out_valid),
    .out_data  (f_out_data),
    .out_ready (word_done),
    .level     (f_level)
  );

  // ----------------------------------------------------------------
  // serial output
  // ----------------------------------------------------------------
  // bit count survives gaps in the clock, so bursts read like one train
  wire frame   = ~cs_n_s & run;
  assign word_done = frame & act_edge & f_out_valid &
                     (bitcnt_q == `ACP_WORD_BITS - 1);   // see (RULE1)

  // sync is deliberately absent from this process
  always @(posedge clock) begin
    if (rst_all | cs_n_s) begin        // see (RULE5)
      bitcnt_q <= 5'h00;
      sr_q     <= {`ACP_WORD_BITS{1'b0}};
    end else if (frame & act_edge) begin
      if (bitcnt_q == `ACP_WORD_BITS - 1) begin
        bitcnt_q <= 5'h00;
      end else begin
        bitcnt_q <= bitcnt_q + 5'h01;  // see (RULE1)
        sr_q     <= {sr_q[`ACP_WORD_BITS-2:0], 1'b0};
      end
    end else if (bitcnt_q == 5'h00) begin
      sr_q <= f_out_data;
    end
  end

  // ----------------------------------------------------------------
  // frame start tracking
  // ----------------------------------------------------------------
  // the return to idle after each bit is legal; only a frame's first edge is judged
  reg fresh_q;

  always @(posedge clock) begin
    if (rst_all | cs_n_s) begin
      fresh_q <= 1'b1;
    end else if (frame & (sclk_rise | sclk_fall)) begin
      fresh_q <= 1'b0;
    end
  end

  // a first transition against the selected idle level flags an error
  always @(posedge clock) begin
    if (rst_all) begin
      pol_err_q <= 1'b0;
    end else if (frame & idle_edge & fresh_q) begin
      pol_err_q <= 1'b1;               // see (RULE2) see (RULE3)
    end else if (wr_stat & pwdata[`ACP_STAT_POLERR]) begin
      pol_err_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // word ready and pin outputs
  // ----------------------------------------------------------------
  wire [11:0] blank_at = (decim_q > `ACP_BLANK_MCLK) ? decim_q - `ACP_BLANK_MCLK : 12'h000;
  wire        near_upd = conv_en_q & (dcnt_q >= blank_at);

  always @(posedge clock) begin
    if (rst_all) begin
      pop_q          <= 1'b0;
      word_ready_n_q <= 1'b1;
      dout_q         <= 1'b0;
      dout_oe_q      <= 1'b0;
      mclk_out_q     <= 1'b0;
      mod_reset_q    <= 1'b1;
      analog_pd_q    <= 1'b0;
    end else begin
      pop_q          <= word_done;
      word_ready_n_q <= ~(f_out_valid & ~near_upd & ~pop_q & ~word_done);   // see (RULE10)
      dout_q         <= sr_q[`ACP_WORD_BITS-1];
      dout_oe_q      <= frame;
      // lags the pin by the synchroniser depth plus one register; adequate for slow clocks only
      mclk_out_q     <= run & ~mclk_s;                                    // see (RULE8)
      mod_reset_q    <= sync_hold | ~run;                                 // see (RULE4)
      analog_pd_q    <= ~run;                                             // see (RULE7)
    end
  end

endmodule

`default_nettype wire

//--- acp_ctrl_checker.sv
`timescale 1ns/10ps
`default_nettype none
module acp_ctrl_checker (
  // apb and system
  input wire logic clock, nrst, psel, penable, pready_q, pslverr_q,
  // pins
  input wire logic cs_n, sync_n, reset_n, standby_n, mclk_in, mclk_out_q,
  input wire logic dout_oe_q, word_ready_n_q, mod_reset_q, analog_pd_q
);
  // ----------------------------------------------------------------
  // pin relations, three clock synchroniser lag allowed
  // ----------------------------------------------------------------
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  property p_rdy; psel && $rose(penable) |-> !pready_q ##1 pready_q; endproperty
  a_rdy: assert property (p_rdy) else $error("pready not on second access");
  property p_one; pready_q |=> !pready_q; endproperty
  a_one: assert property (p_one) else $error("pready longer than one cycle");
  property p_err; pslverr_q |-> pready_q; endproperty
  a_err: assert property (p_err) else $error("pslverr without pready");
  property p_sync; !sync_n [*4] |-> mod_reset_q; endproperty
  a_sync: assert property (p_sync) else $error("modulator not held");
  property p_stby; !standby_n [*4] |-> analog_pd_q && !mclk_out_q; endproperty
  a_stby: assert property (p_stby) else $error("standby not entered");
  property p_rst; !reset_n [*4] |-> mod_reset_q && word_ready_n_q && !dout_oe_q; endproperty
  a_rst: assert property (p_rst) else $error("reset pin ignored");
  property p_oe; (!cs_n && standby_n && reset_n) [*5] |-> dout_oe_q; endproperty
  a_oe: assert property (p_oe) else $error("data line not driven");
  property p_idle; cs_n [*4] |-> !dout_oe_q; endproperty
  a_idle: assert property (p_idle) else $error("data line driven while idle");
  property p_mclk; standby_n [*6] ##0 $rose(mclk_in) |-> ##3 !mclk_out_q; endproperty
  a_mclk: assert property (p_mclk) else $error("clock out not inverted");
endmodule
bind acp_ctrl acp_ctrl_checker chk_u (.*);
`default_nettype wire

//--- acp_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module acp_host_model (
  // serial pins
  input  wire logic        edge_polarity_sel, dout_q, dout_oe_q,
  output var  logic        sclk, cs_n, got,
  output var  logic [23:0] word
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    got  = 1'b0;
    word = 24'h0;
  end
  // clock stands still at the idle level between frames
  always @(edge_polarity_sel) if (cs_n) sclk = edge_polarity_sel;
  // gap above zero splits the word into one-bit bursts
  task automatic read_word(input int gap);
    int i;
    cs_n = 1'b0;
    #300;
    for (i = 0; i < 24; i++) begin
      word = {word[22:0], dout_oe_q ? dout_q : 1'bx};
      sclk = ~edge_polarity_sel;
      #100;
      sclk = edge_polarity_sel;
      #(100 + gap);
    end
    cs_n = 1'b1;
    got  = 1'b1;
    #5;
    got  = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- acp_ctrl_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "acp_regs.vh"
module acp_ctrl_tb_top;
  // ----------------------------------------------------------------
  // signals
  // ----------------------------------------------------------------
  logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
  logic        sync_n = 1, reset_n = 1, standby_n = 1, mclk_in = 0, mod_bit = 0;
  logic        edge_polarity_sel = 0, sclk, cs_n, got, dout_q, dout_oe_q;
  logic        pready_q, pslverr_q, word_ready_n_q, mclk_out_q, mod_reset_q, analog_pd_q;
  logic [1:0]  mc = 2'h0;
  logic [11:0] paddr = 12'h0;
  logic [23:0] word, dw;
  logic [31:0] pwdata = 32'h0, prdata_q, rd, seed = 32'hb562fe66;
  logic [32:0] qv[$], qm[$];
  int          err_total = 0, tests_run = 0, k;
  acp_ctrl dut_u (.*);
  acp_host_model host_u (.*);
  always #12.5 clock = ~clock;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // random modulator bits, master clock at an eighth of the system rate
  always @(posedge clock) begin
    seed    <= lfsr(seed);
    mod_bit <= seed[0];
    mc      <= mc + 2'h1;
    if (mc == 2'h3) mclk_in <= ~mclk_in;
  end
  // ----------------------------------------------------------------
  // checking
  // ----------------------------------------------------------------
  task automatic chk(input logic [32:0] g);
    logic [32:0] v, m;
    v = qv.pop_front();
    m = qm.pop_front();
    if (m != 33'h0) begin
      tests_run++;
      if ((g & m) !== (v & m)) begin
        err_total++;
        $display("BAD %0t got %h exp %h", $time, g, v);
      end
    end
  endtask
  always @(posedge clock)
    if (psel && penable && pready_q === 1'b1 && !pwrite) chk({pslverr_q, prdata_q});
  always @(posedge got) chk({9'h0, word});
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  initial begin
    #2000000;
    err_total++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [32:0] v, m, output logic [31:0] r);
    int n;
    if (!w) begin
      qv.push_back(v);
      qm.push_back(m);
    end
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready_q !== 1'b1 && n < 50);
    if (n >= 50) err_total++;
    r = prdata_q;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wait_ready;
    int n;
    n = 0;
    while (word_ready_n_q !== 1'b0 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    if (n >= 20000) err_total++;
  endtask
  initial begin
    repeat (2) @(posedge clock);
    nrst <= 1'b1;
    apb(0, `ACP_OFF_CTRL, 0, {1'b0, `ACP_CTRL_RST}, '1, rd);
    apb(0, `ACP_OFF_STAT, 0, 33'h0, 33'h3f1f, rd);
    apb(0, 12'h00c, 0, 33'h1_0000_0000, '1, rd);
    standby_n <= 1'b0;
    repeat (20) @(posedge clock);
    apb(0, `ACP_OFF_STAT, 0, 33'h800, 33'h800, rd);
    standby_n <= 1'b1;
    for (k = 0; k < 2; k++) begin
      edge_polarity_sel <= k[0];
      reset_n <= 1'b0;
      repeat (4) @(posedge clock);
      apb(1, `ACP_OFF_CTRL, 32'h0004_0000, 0, 0, rd);
      apb(0, `ACP_OFF_CTRL, 0, {1'b0, `ACP_CTRL_RST}, '1, rd);
      reset_n <= 1'b1;
      apb(1, `ACP_OFF_CTRL, 32'h0258_0001, 0, 0, rd);
      apb(0, `ACP_OFF_CTRL, 0, 33'h0258_0001, '1, rd);
      wait_ready();
      apb(0, `ACP_OFF_DATA, 0, 0, 0, rd);
      dw = rd[23:0];
      sync_n <= ~k[0];
      repeat (4) @(posedge clock);
      apb(0, `ACP_OFF_STAT, 0, {19'h0, k[0], k[0], 12'h101}, 33'h351f, rd);
      qv.push_back({9'h0, dw});
      qm.push_back(33'hff_ffff);
      #7 host_u.read_word(k * 300);
      @(posedge clock);
      apb(0, `ACP_OFF_STAT, 0, {19'h0, k[0], k[0], 12'h000}, 33'h351f, rd);
      sync_n <= 1'b1;
    end
    apb(1, `ACP_OFF_CTRL, 32'h0004_0001, 0, 0, rd);
    repeat (1000) @(posedge clock);
    apb(0, `ACP_OFF_STAT, 0, 33'h10, 33'h1f, rd);
    apb(1, `ACP_OFF_CTRL, 32'h0004_0000, 0, 0, rd);
    for (k = 0; k < 17; k++) begin
      qv.push_back(33'h0);
      qm.push_back(33'h0);
      #7 host_u.read_word(400);
      @(posedge clock);
    end
    apb(0, `ACP_OFF_STAT, 0, 33'h0, 33'h11f, rd);
    apb(1, `ACP_OFF_CTRL, 32'h0004_0002, 0, 0, rd);
    apb(0, `ACP_OFF_STAT, 0, 33'h200, 33'h200, rd);
    sync_n <= 1'b0;
    repeat (4) @(posedge clock);
    apb(0, `ACP_OFF_STAT, 0, 33'h1000, 33'h1200, rd);
    sync_n <= 1'b1;
    tally_and_finish();
  end
endmodule
`default_nettype wire
